// ---- air_cfg.svh ----
// constants for the converter's i2c register access block
`ifndef AIR_CFG_SVH
`define AIR_CFG_SVH

// ----------------------------------------
// bus addressing
// ----------------------------------------
`define AIR_ADDR_BASE 7'h48
`define AIR_PTR_CONV 2'h0
`define AIR_PTR_CFG 2'h1

// ----------------------------------------
// configuration register
// ----------------------------------------
`define AIR_CFG_RESET 16'h0003
`define AIR_SEL_LSB 12
`define AIR_SEL_MSB 14

// ----------------------------------------
// timing at the 25 MHz core clock
// ----------------------------------------
`define AIR_CORE_MHZ 25
`define AIR_SDA_HOLD_NS 100
`define AIR_SDA_HOLD_CYC ((`AIR_SDA_HOLD_NS * `AIR_CORE_MHZ + 999) / 1000)

`endif

// ---- air_pkg.sv ----
// types for the converter's i2c register access block
package air_pkg;

  typedef enum logic [2:0] {
    AIR_ST_IDLE = 3'b000,
    AIR_ST_RX = 3'b001,
    AIR_ST_ACK = 3'b010,
    AIR_ST_TX = 3'b011,
    AIR_ST_RACK = 3'b100
  } air_state_t;

  typedef enum logic [2:0] {
    AIR_CH0 = 3'b000,
    AIR_CH1 = 3'b001,
    AIR_CH2 = 3'b010,
    AIR_CH3 = 3'b011,
    AIR_GND = 3'b100
  } air_chan_t;

endpackage

// ---- air_word_if.sv ----
// word carrier between the link and core clock domains
`timescale 1ns/1ps
`default_nettype none

interface air_word_if #(parameter int W = 16);
  logic [W-1:0] srcData;
  logic srcSend;
  logic srcBusy;
  logic [W-1:0] dstData;
  logic dstValid;
  modport mover (input srcData, input srcSend, output srcBusy,
                 output dstData, output dstValid);
  modport user (output srcData, output srcSend, input srcBusy,
                input dstData, input dstValid);
endinterface

`default_nettype wire

// ---- air_xfer.sv ----
// toggle handshake that moves one word between two clock domains
`timescale 1ns/1ps
`default_nettype none

module air_xfer #(
  parameter int W = 16
) (
  // source side
  input wire logic srcClk,
  input wire logic srcRst,
  // destination side
  input wire logic dstClk,
  input wire logic dstRst,
  // word carrier
  air_word_if.mover wd
);
  logic reqTgl;
  logic [W-1:0] holdData;
  logic ackMeta;
  logic ackSync;
  logic reqMeta;
  logic reqSync;
  logic reqSeen;

  // ----------------------------------------
  // source domain
  // ----------------------------------------
  // data is held until the acknowledge returns, so it is stable when read
  assign wd.srcBusy = reqTgl != ackSync;

  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      reqTgl <= 1'b0;
      holdData <= '0;
    end else if (wd.srcSend && !wd.srcBusy) begin
      reqTgl <= ~reqTgl;
      holdData <= wd.srcData;
    end
  end

  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end else begin
      ackMeta <= reqSeen;
      ackSync <= ackMeta;
    end
  end

  // ----------------------------------------
  // destination domain
  // ----------------------------------------
  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
      reqSeen <= 1'b0;
      wd.dstValid <= 1'b0;
      wd.dstData <= '0;
    end else begin
      reqMeta <= reqTgl;
      reqSync <= reqMeta;
      reqSeen <= reqSync;
      wd.dstValid <= reqSync != reqSeen;
      if (reqSync != reqSeen) begin
        wd.dstData <= holdData;
      end
    end
  end
endmodule

`default_nettype wire

// ---- air_top.sv ----
// i2c target register access of a small four-input converter
`timescale 1ns/1ps
`default_nettype none
`include "air_cfg.svh"

module air_top
  import air_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link clock, samples the bus pins
  input wire logic linkClk,
  // bus pins, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // address strap
  input wire logic [1:0] addrSel,
  // conversion engine side
  input wire logic [15:0] convResult,
  output logic [15:0] configReg,
  output logic [2:0] inputSelect,
  output var air_chan_t measPos,
  output var air_chan_t measNeg
);
  air_word_if #(.W(16)) cfgWd ();
  air_word_if #(.W(16)) convWd ();

  logic rstMeta, linkRst;
  logic sclMeta, sclS, sclD, sdaMeta, sdaS, sdaD;
  logic [1:0] addrMeta, addrSync;
  logic [6:0] myAddr;
  logic sclRise, sclFall, startDet, stopDet;
  air_state_t state;
  logic [3:0] bitCnt;
  logic [2:0] byteIdx;
  logic [7:0] shiftReg, msbHold, next_tx;
  logic [1:0] ptr;
  logic rnw, mAck, cfgSend;
  logic [15:0] cfgShadow, convShadow, readWord;
  localparam logic [15:0] CfgResetVal = `AIR_CFG_RESET;

  // ----------------------------------------
  // link reset and pin synchronisers
  // ----------------------------------------
  always_ff @(posedge linkClk) begin
    rstMeta <= rst;
    linkRst <= rstMeta;
  end

  // oversampling keeps up with every bus speed grade
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      {sclMeta, sclS, sclD} <= 3'h7;
      {sdaMeta, sdaS, sdaD} <= 3'h7;
    end else begin
      {sclMeta, sclS, sclD} <= {sclIn, sclMeta, sclS};
      {sdaMeta, sdaS, sdaD} <= {sdaIn, sdaMeta, sdaS};
    end
  end

  // strap pair is never cleared, it must settle while reset is held
  always_ff @(posedge linkClk) begin
    addrMeta <= addrSel;
    addrSync <= addrMeta;
  end

  // strap caught while the link reset is held
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      myAddr <= `AIR_ADDR_BASE | {5'h00, addrSync};
    end
  end

  assign sclRise = sclS && !sclD;
  assign sclFall = !sclS && sclD;
  assign startDet = sclS && sclD && !sdaS && sdaD;
  assign stopDet = sclS && sclD && sdaS && !sdaD;

  // the clock line is only ever listened to
  always_ff @(posedge linkClk) begin
    sclOut <= 1'b0;
    sclOe <= 1'b0;
    sdaOut <= 1'b0;
  end

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  always_comb begin
    unique case (ptr)
      `AIR_PTR_CONV: readWord = convShadow;
      `AIR_PTR_CFG: readWord = cfgShadow;
      default: readWord = 16'h0000;
    endcase
    unique case (byteIdx)
      3'h1: next_tx = readWord[15:8];
      3'h2: next_tx = readWord[7:0];
      default: next_tx = 8'h00;
    endcase
  end

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      state <= AIR_ST_IDLE;
      bitCnt <= 4'h0;
      byteIdx <= 3'h0;
      shiftReg <= 8'h00;
      msbHold <= 8'h00;
      ptr <= `AIR_PTR_CONV;
      rnw <= 1'b0;
      mAck <= 1'b0;
      sdaOe <= 1'b0;
      cfgShadow <= `AIR_CFG_RESET;
      cfgSend <= 1'b0;
    end else begin
      cfgSend <= 1'b0;
      if (startDet) begin
        // pointer is left alone so a bare read reuses it
        state <= AIR_ST_RX;
        bitCnt <= 4'h0;
        byteIdx <= 3'h0;
        sdaOe <= 1'b0;
      end else if (stopDet) begin
        state <= AIR_ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        unique case (state)
          AIR_ST_IDLE: begin
          end
          AIR_ST_RX: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              if (byteIdx != 3'h7) begin
                byteIdx <= byteIdx + 3'h1;
              end
              if (byteIdx == 3'h0) begin
                if (shiftReg[7:1] == myAddr) begin
                  rnw <= shiftReg[0];
                  sdaOe <= 1'b1;
                  state <= AIR_ST_ACK;
                end else begin
                  state <= AIR_ST_IDLE;
                end
              end else begin
                sdaOe <= 1'b1;
                state <= AIR_ST_ACK;
                if (byteIdx == 3'h1) begin
                  ptr <= shiftReg[1:0];
                end
                if (byteIdx == 3'h2) begin
                  msbHold <= shiftReg;
                end
                // only the configuration word is held here
                if (byteIdx == 3'h3 && ptr == `AIR_PTR_CFG) begin
                  cfgShadow <= {msbHold, shiftReg};
                  cfgSend <= 1'b1;
                end
              end
            end
          end
          AIR_ST_ACK: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (rnw) begin
                state <= AIR_ST_TX;
                shiftReg <= next_tx;
                sdaOe <= ~next_tx[7];
                byteIdx <= byteIdx + 3'h1;
              end else begin
                state <= AIR_ST_RX;
                sdaOe <= 1'b0;
              end
            end
          end
          AIR_ST_TX: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall) begin
              if (bitCnt == 4'h8) begin
                sdaOe <= 1'b0;
                state <= AIR_ST_RACK;
              end else begin
                shiftReg <= {shiftReg[6:0], 1'b0};
                sdaOe <= ~shiftReg[6];
              end
            end
          end
          AIR_ST_RACK: begin
            if (sclRise) begin
              mAck <= ~sdaS;
            end else if (sclFall) begin
              bitCnt <= 4'h0;
              if (mAck) begin
                state <= AIR_ST_TX;
                shiftReg <= next_tx;
                sdaOe <= ~next_tx[7];
                if (byteIdx != 3'h7) begin
                  byteIdx <= byteIdx + 3'h1;
                end
              end else begin
                state <= AIR_ST_IDLE;
              end
            end
          end
          default: begin
            state <= AIR_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // domain crossings
  // ----------------------------------------
  // a new config word is at least a byte time later, so none is dropped
  assign cfgWd.srcData = cfgShadow;
  assign cfgWd.srcSend = cfgSend;
  assign convWd.srcData = convResult;
  assign convWd.srcSend = 1'b1;

  air_xfer #(.W(16)) cfgX (
    .srcClk(linkClk), .srcRst(linkRst),
    .dstClk(core_clk), .dstRst(rst), .wd(cfgWd)
  );

  air_xfer #(.W(16)) convX (
    .srcClk(core_clk), .srcRst(rst),
    .dstClk(linkClk), .dstRst(linkRst), .wd(convWd)
  );

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      convShadow <= 16'h0000;
    end else if (convWd.dstValid) begin
      convShadow <= convWd.dstData;
    end
  end

  // ----------------------------------------
  // core side configuration and input choice
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      configReg <= `AIR_CFG_RESET;
      inputSelect <= CfgResetVal[`AIR_SEL_MSB:`AIR_SEL_LSB];
    end else if (cfgWd.dstValid) begin
      configReg <= cfgWd.dstData;
      inputSelect <= cfgWd.dstData[`AIR_SEL_MSB:`AIR_SEL_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      measPos <= AIR_CH0;
      measNeg <= AIR_CH1;
    end else if (inputSelect[2]) begin
      // codes 4 to 7 take one input against ground
      measPos <= air_chan_t'({1'b0, inputSelect[1:0]});
      measNeg <= AIR_GND;
    end else if (inputSelect == 3'h0) begin
      measPos <= AIR_CH0;
      measNeg <= AIR_CH1;
    end else begin
      // codes 1 to 3 share the fourth input as common point
      measPos <= air_chan_t'(inputSelect - 3'h1);
      measNeg <= AIR_CH3;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence sAddrDone;
    state == AIR_ST_RX && sclFall && bitCnt == 4'h8 && byteIdx == 3'h0
      && !startDet && !stopDet;
  endsequence

  sequence sReadStart;
    state == AIR_ST_ACK && sclFall && rnw && byteIdx == 3'h1
      && !startDet && !stopDet;
  endsequence

  noStretch_a: assert property (@(posedge linkClk) disable iff (linkRst)
    sclRise |-> ##[1:3] !sclOe) else $error("clock line driven");
  addrAck_a: assert property (@(posedge linkClk) disable iff (linkRst)
    sAddrDone and (shiftReg[7:1] == myAddr) |=> sdaOe && state == AIR_ST_ACK)
    else $error("own address not acknowledged");
  addrNack_a: assert property (@(posedge linkClk) disable iff (linkRst)
    sAddrDone and (shiftReg[7:1] != myAddr) |=> !sdaOe [*2])
    else $error("foreign address acknowledged");
  ptrLoad_a: assert property (@(posedge linkClk) disable iff (linkRst)
    state == AIR_ST_RX && sclFall && bitCnt == 4'h8 && byteIdx == 3'h1
      && !startDet && !stopDet |=> ptr == $past(shiftReg[1:0]))
    else $error("pointer not loaded");
  cfgWrite_a: assert property (@(posedge linkClk) disable iff (linkRst)
    cfgSend |-> ptr == `AIR_PTR_CFG && cfgShadow[15:8] == msbHold
      && cfgShadow[7:0] == shiftReg) else $error("bad config write");
  readMsb_a: assert property (@(posedge linkClk) disable iff (linkRst)
    sReadStart |=> shiftReg == $past(readWord[15:8]) && state == AIR_ST_TX)
    else $error("read did not start with high byte");
  ptrKeep_a: assert property (@(posedge linkClk) disable iff (linkRst)
    startDet |=> ptr == $past(ptr)) else $error("pointer lost");
  selMap_a: assert property (@(posedge core_clk) disable iff (rst)
    inputSelect == 3'h1 |=> measPos == AIR_CH0 && measNeg == AIR_CH3)
    else $error("common input setting wrong");
endmodule

`default_nettype wire

// ---- air_ctl_model.sv ----
// behavioural bus controller that drives the target's pins
`timescale 1ns/1ps
`default_nettype none

module air_ctl_model #(
  parameter int Q = 125
) (
  // resolved data line
  input wire logic sdaLine,
  // controller drives, high = released to the pull-up
  output logic sclDrv,
  output logic sdaDrv
);
  // quarter bit time; the bench may shorten it for a faster controller
  int q = Q;

  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end

  // ----------------------------------------
  // framing
  // ----------------------------------------
  task automatic startCond();
    sdaDrv = 1'b1;
    #q sclDrv = 1'b1;
    #q sdaDrv = 1'b0;
    #q sclDrv = 1'b0;
    #q;
  endtask

  task automatic stopCond();
    sdaDrv = 1'b0;
    #q sclDrv = 1'b1;
    #q sdaDrv = 1'b1;
    #q;
  endtask

  // ----------------------------------------
  // bits and bytes
  // ----------------------------------------
  // data moves a full quarter after the clock falls, well past the hold
  task automatic clockBit(input logic b, output logic s);
    sdaDrv = b;
    #q sclDrv = 1'b1;
    #q s = sdaLine;
    #q sclDrv = 1'b0;
    #q;
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(b[i], s);
    end
    clockBit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recvByte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clockBit(1'b1, s);
      b[i] = s;
    end
    clockBit(last, s);
  endtask
endmodule

`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the converter's register access block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import air_pkg::*;
  logic core_clk, rst, linkClk;
  logic sclDrv, sdaDrv, scl, sda;
  logic sclOut, sclOe, sdaOut, sdaOe;
  logic [1:0] addrSel;
  logic [15:0] convResult, configReg, rd;
  logic [2:0] inputSelect;
  air_chan_t measPos, measNeg;
  logic ack;
  logic [6:0] own;
  logic [15:0] d;
  int fails, checks;

  // open-drain resolution with pull-ups
  assign scl = sclDrv & ~(sclOe & ~sclOut);
  assign sda = sdaDrv & ~(sdaOe & ~sdaOut);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  air_top air_top_inst (.core_clk(core_clk), .rst(rst), .linkClk(linkClk),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
    .convResult(convResult), .configReg(configReg),
    .inputSelect(inputSelect), .measPos(measPos), .measNeg(measNeg));
  air_ctl_model air_ctl_model_inst (.sdaLine(sda), .sclDrv(sclDrv),
    .sdaDrv(sdaDrv));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic end_sim();
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // the clock line must stay released whenever reset is low
  always @(posedge linkClk) begin
    if (rst === 1'b0 && sclOe !== 1'b0) begin
      fails++;
      $display("[FAIL] %0t clock line driven", $time);
    end
  end

  initial begin
    #600000;
    fails++;
    $display("[FAIL] %0t run hung", $time);
    end_sim();
  end

  // ----------------------------------------
  // bus transfers
  // ----------------------------------------
  task automatic wrReg(input logic [6:0] a, input logic [1:0] p,
                       input logic [15:0] w, input logic full,
                       output logic ak);
    logic x;
    air_ctl_model_inst.startCond();
    air_ctl_model_inst.sendByte({a, 1'b0}, ak);
    if (ak) begin
      air_ctl_model_inst.sendByte({6'h00, p}, x);
      if (full) begin
        air_ctl_model_inst.sendByte(w[15:8], x);
        air_ctl_model_inst.sendByte(w[7:0], x);
      end
    end
    air_ctl_model_inst.stopCond();
  endtask

  task automatic rdReg(input logic [6:0] a, output logic [15:0] r);
    logic x;
    air_ctl_model_inst.startCond();
    air_ctl_model_inst.sendByte({a, 1'b1}, x);
    air_ctl_model_inst.recvByte(1'b0, r[15:8]);
    air_ctl_model_inst.recvByte(1'b1, r[7:0]);
    air_ctl_model_inst.stopCond();
  endtask

  task automatic waitCfg(input logic [15:0] w);
    int n;
    n = 0;
    while (configReg !== w && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(configReg, w);
    if (n >= 200) begin
      end_sim();
    end
    repeat (2) @(negedge core_clk);
  endtask

  task automatic doReset(input logic [1:0] a);
    @(negedge core_clk);
    addrSel = a;
    rst = 1'b1;
    repeat (12) @(negedge core_clk);
    chk(configReg, 16'h0003);
    chk({13'h0000, measNeg}, 16'h0001);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    fails = 0;
    checks = 0;
    rst = 1'b1;
    addrSel = 2'h0;
    convResult = 16'h0000;
    // every strap value, each time checking a neighbour stays silent
    for (int a = 0; a < 4; a++) begin
      doReset(a[1:0]);
      own = 7'h48 + 7'(a);
      wrReg(own ^ 7'h01, 2'h1, 16'h1234, 1'b1, ack);
      chk({15'h0000, ack}, 16'h0000);
      chk(configReg, 16'h0003);
      d = 16'h8583 ^ 16'(a << 4);
      wrReg(own, 2'h1, d, 1'b1, ack);
      chk({15'h0000, ack}, 16'h0001);
      waitCfg(d);
      rdReg(own, rd);
      chk(rd, d);
    end
    // all input select codes and their input pairs
    for (int k = 0; k < 8; k++) begin
      d = {1'b1, 3'(k), 12'h583};
      wrReg(own, 2'h1, d, 1'b1, ack);
      waitCfg(d);
      chk({13'h0000, inputSelect}, 16'(k));
      chk({13'h0000, measPos}, 16'(k == 0 ? 0 : k < 4 ? k - 1 : k - 4));
      chk({13'h0000, measNeg}, 16'(k == 0 ? 1 : k < 4 ? 3 : 4));
    end
    // conversion word, pointer only write, then repeated reads
    @(negedge core_clk);
    convResult = 16'hA5C3;
    repeat (30) @(negedge core_clk);
    wrReg(own, 2'h0, 16'h0000, 1'b0, ack);
    rdReg(own, rd);
    chk(rd, 16'hA5C3);
    rdReg(own, rd);
    chk(rd, 16'hA5C3);
    wrReg(own, 2'h1, 16'h0000, 1'b0, ack);
    rdReg(own, rd);
    chk(rd, d);
    chk(configReg, d);
    // a faster controller, still keeping the data hold after clock falls
    air_ctl_model_inst.q = 100;
    wrReg(own, 2'h1, 16'h8483, 1'b1, ack);
    chk({15'h0000, ack}, 16'h0001);
    waitCfg(16'h8483);
    rdReg(own, rd);
    chk(rd, 16'h8483);
    end_sim();
  end
endmodule

`default_nettype wire
